// file: pkg/sicr_cfg.svh
// Purpose: constants of the identifier read-out block
// Assumes: included by the design file and its package users
// Notes:   values in bus order, most significant first
`ifndef SICR_CFG_SVH
`define SICR_CFG_SVH

`define SICR_CMD_ID_FIRST  16'h367c
`define SICR_CMD_ID_SECOND 16'he102
`define SICR_CRC_POLY      8'h31
`define SICR_CRC_INIT      8'hff
`define SICR_ID_WORDS      3'h6
`define SICR_BYTE_BITS     4'h8
`define SICR_LAST_BIT      4'h7
`define SICR_POS_MSB       2'h0
`define SICR_POS_LSB       2'h1
`define SICR_POS_CRC       2'h2
`define SICR_FLOW_MAX      16'sh6590
`define SICR_FLOW_MIN      16'sh9a70
`define SICR_WORD_SHIFT    4'h0

`endif

// file: pkg/sicr_pkg.sv
// Purpose: types of the identifier read-out block
// Assumes: nothing
// Notes:   all state of the top module lives in sicr_state_t
package sicr_pkg;

   typedef enum logic [2:0] {
      SICR_IDLE = 3'b000,
      SICR_ADDR = 3'b001,
      SICR_ACK  = 3'b010,
      SICR_RX   = 3'b011,
      SICR_TX   = 3'b100,
      SICR_MACK = 3'b101
   } sicr_phase_t;

   // open-drain data pin, as seen from the device
   typedef struct packed {
      logic sda_out;
      logic sda_oe;
   } sicr_pin_out_t;

   typedef struct packed {
      logic        [15:0] flow_word;
      logic        [15:0] temp_word;
   } sicr_meas_t;

   typedef struct packed {
      sicr_phase_t   phase;
      logic          scl_q;
      logic          sda_q;
      logic [7:0]    shift;
      logic [3:0]    bit_cnt;
      logic          rd_dir;
      logic          have_hi;
      logic [7:0]    cmd_hi;
      logic          armed;
      logic          id_ready;
      logic [2:0]    word_idx;
      logic [1:0]    pos;
      logic [7:0]    crc;
      logic          mack_ok;
      sicr_pin_out_t pin;
      sicr_meas_t    meas;
   } sicr_state_t;

endpackage

// file: verilog/sicr_readout.sv
// Purpose: I2C target returning product number and serial number with CRC-8
// Assumes: scl and sda inputs already synchronous to core_clk, bus far slower
// Notes:   flow word is clamped, temperature passed through, both presented, not sent on the bus here
`timescale 1ns/1ns
`include "sicr_cfg.svh"

// Notes on behaviour
// - 0x367C then 0xE102 arms identifier read-out; data only after second
// - read returns six 16-bit words, msb first, each followed by crc byte
// - first two words give 32-bit product and revision, msb first
// - lowest 8 bits of product value are silicon revision
// - last four words give 64-bit serial, bits 63:56 down to 7:0
// - each crc covers only the two data bytes just sent
// - flow word is 16-bit two's complement
// - flow word held within -26000 to 26000
// - temperature word 16-bit two's complement, reader divides by 200
module sicr_readout #(
   parameter logic [6:0]  BUS_ADDR    = 7'h40,
   // arbitrary neutral product number, not a real part code
   parameter logic [23:0] PRODUCT_NUM = 24'h0a0b0c,
   parameter logic [7:0]  REVISION    = 8'h01,
   parameter logic [63:0] SERIAL_NUM  = 64'h0123_4567_89ab_cdef
) (
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe,
   input  wire logic [15:0]         flow_raw,
   input  wire logic [15:0]         temp_raw,
   output sicr_pkg::sicr_meas_t     meas_out,
   output logic                     id_ready
);
   import sicr_pkg::*;

   // ************************************************************
   // identifier image and checksum
   // ************************************************************
   // word order of the image
   localparam logic [95:0] ID_IMAGE = {PRODUCT_NUM, REVISION, SERIAL_NUM};

   function automatic logic [7:0] crc8_byte(input logic [7:0] c_in, input logic [7:0] d);
      logic [7:0] c;
      c = c_in;
      for (int i = 7; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ `SICR_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   sicr_state_t st_reg;
   sicr_state_t st_next;

   logic        scl_rise;
   logic        scl_fall;
   logic        bus_start;
   logic        bus_stop;
   logic [95:0] id_shifted;
   logic [15:0] cur_word;
   logic [7:0]  cur_byte;
   logic [15:0] cmd_full;

   assign scl_rise   = scl_in & ~st_reg.scl_q;
   assign scl_fall   = ~scl_in & st_reg.scl_q;
   assign bus_start  = scl_in & st_reg.scl_q & st_reg.sda_q & ~sda_in;
   assign bus_stop   = scl_in & st_reg.scl_q & ~st_reg.sda_q & sda_in;
   assign id_shifted = ID_IMAGE << {st_reg.word_idx, `SICR_WORD_SHIFT};
   assign cur_word   = id_shifted[95:80];
   assign cmd_full   = {st_reg.cmd_hi, st_reg.shift};

   // msb, lsb, then checksum of that word
   always_comb begin
      if (st_reg.pos == `SICR_POS_CRC) begin
         cur_byte = st_reg.crc;
      end else if (st_reg.pos == `SICR_POS_MSB) begin
         cur_byte = cur_word[15:8];
      end else begin
         cur_byte = cur_word[7:0];
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_next       = st_reg;
      st_next.scl_q = scl_in;
      st_next.sda_q = sda_in;

      // two's complement temperature word passes through unchanged
      st_next.meas.temp_word = temp_raw;
      // clamp flow to sensor output limit
      if ($signed(flow_raw) > $signed(`SICR_FLOW_MAX)) begin
         st_next.meas.flow_word = `SICR_FLOW_MAX;
      end else if ($signed(flow_raw) < $signed(`SICR_FLOW_MIN)) begin
         st_next.meas.flow_word = `SICR_FLOW_MIN;
      end else begin
         st_next.meas.flow_word = flow_raw;
      end

      if (bus_stop) begin
         st_next.phase      = SICR_IDLE;
         st_next.pin.sda_oe = 1'b0;
      end else if (bus_start) begin
         // repeated start is treated like a fresh one
         st_next.phase      = SICR_ADDR;
         st_next.bit_cnt    = 4'h0;
         st_next.pin.sda_oe = 1'b0;
      end else begin
         case (st_reg.phase)
            SICR_IDLE: begin
               st_next.pin.sda_oe = 1'b0;
            end
            SICR_ADDR: begin
               if (scl_rise) begin
                  st_next.shift   = {st_reg.shift[6:0], sda_in};
                  st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
               end else if (scl_fall && st_reg.bit_cnt == `SICR_BYTE_BITS) begin
                  // read header refused until both commands seen
                  if (st_reg.shift[7:1] == BUS_ADDR && (!st_reg.shift[0] || st_reg.id_ready)) begin
                     st_next.phase      = SICR_ACK;
                     st_next.rd_dir     = st_reg.shift[0];
                     st_next.pin.sda_oe = 1'b1;
                     st_next.have_hi    = 1'b0;
                     st_next.word_idx   = 3'h0;
                     st_next.pos        = `SICR_POS_MSB;
                     st_next.crc        = `SICR_CRC_INIT;
                  end else begin
                     st_next.phase = SICR_IDLE;
                  end
               end
            end
            SICR_ACK: begin
               if (scl_fall) begin
                  st_next.bit_cnt = 4'h0;
                  if (st_reg.rd_dir) begin
                     st_next.phase      = SICR_TX;
                     st_next.shift      = cur_byte;
                     st_next.pin.sda_oe = ~cur_byte[7];
                  end else begin
                     st_next.phase      = SICR_RX;
                     st_next.pin.sda_oe = 1'b0;
                  end
               end
            end
            SICR_RX: begin
               if (scl_rise) begin
                  st_next.shift   = {st_reg.shift[6:0], sda_in};
                  st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
               end else if (scl_fall && st_reg.bit_cnt == `SICR_BYTE_BITS) begin
                  st_next.phase      = SICR_ACK;
                  st_next.pin.sda_oe = 1'b1;
                  if (!st_reg.have_hi) begin
                     st_next.cmd_hi  = st_reg.shift;
                     st_next.have_hi = 1'b1;
                  end else begin
                     st_next.have_hi = 1'b0;
                     // arming survives within and across transactions until another command word arrives
                     if (cmd_full == `SICR_CMD_ID_FIRST) begin
                        st_next.armed    = 1'b1;
                        st_next.id_ready = 1'b0;
                     end else if (cmd_full == `SICR_CMD_ID_SECOND && st_reg.armed) begin
                        st_next.armed    = 1'b0;
                        st_next.id_ready = 1'b1;
                     end else begin
                        st_next.armed    = 1'b0;
                        st_next.id_ready = 1'b0;
                     end
                  end
               end
            end
            SICR_TX: begin
               if (scl_fall) begin
                  if (st_reg.bit_cnt == `SICR_LAST_BIT) begin
                     st_next.phase      = SICR_MACK;
                     st_next.pin.sda_oe = 1'b0;
                     if (st_reg.pos == `SICR_POS_CRC) begin
                        st_next.crc      = `SICR_CRC_INIT;
                        st_next.pos      = `SICR_POS_MSB;
                        st_next.word_idx = st_reg.word_idx + 3'h1;
                     end else begin
                        st_next.crc = crc8_byte(st_reg.crc, cur_byte);
                        st_next.pos = st_reg.pos + 2'h1;
                     end
                  end else begin
                     st_next.shift      = {st_reg.shift[6:0], 1'b0};
                     st_next.pin.sda_oe = ~st_reg.shift[6];
                     st_next.bit_cnt    = st_reg.bit_cnt + 4'h1;
                  end
               end
            end
            SICR_MACK: begin
               if (scl_rise) begin
                  st_next.mack_ok = ~sda_in;
               end else if (scl_fall) begin
                  // eighteen bytes then the bus is released
                  if (st_reg.mack_ok && st_reg.word_idx != `SICR_ID_WORDS) begin
                     st_next.phase      = SICR_TX;
                     st_next.bit_cnt    = 4'h0;
                     st_next.shift      = cur_byte;
                     st_next.pin.sda_oe = ~cur_byte[7];
                  end else begin
                     st_next.phase = SICR_IDLE;
                  end
               end
            end
            default: begin
               st_next.phase      = SICR_IDLE;
               st_next.pin.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg       <= '0;
         st_reg.scl_q <= 1'b1;
         st_reg.sda_q <= 1'b1;
         st_reg.crc   <= `SICR_CRC_INIT;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sda_out  = st_reg.pin.sda_out;
   assign sda_oe   = st_reg.pin.sda_oe;
   assign meas_out = st_reg.meas;
   assign id_ready = st_reg.id_ready;

endmodule

// file: verification/sicr_readout_monitor.sv
// Purpose: port checks of sicr_readout
// Assumes: scl levels last two clocks or more
// Notes:   bound to every sicr_readout
`timescale 1ns/1ns
`include "sicr_cfg.svh"
module sicr_readout_monitor
   import sicr_pkg::*;
(
   input wire logic                 core_clk,
   input wire logic                 sys_rst,
   input wire logic                 scl_in,
   input wire logic                 sda_out,
   input wire logic                 sda_oe,
   input wire logic [15:0]          flow_raw,
   input wire logic [15:0]          temp_raw,
   input wire sicr_pkg::sicr_meas_t meas_out,
   input wire logic                 id_ready
);
   logic [1:0] oe_rises_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   function automatic logic [15:0] lim(input logic [15:0] v);
      if ($signed(v) > $signed(`SICR_FLOW_MAX)) return `SICR_FLOW_MAX;
      if ($signed(v) < $signed(`SICR_FLOW_MIN)) return `SICR_FLOW_MIN;
      return v;
   endfunction
   // scl rises seen while pulling low; data zeros span several
   always_ff @(posedge core_clk) begin
      if (sys_rst || !sda_oe) oe_rises_reg <= 2'h0;
      else if ($rose(scl_in) && oe_rises_reg != 2'h3) oe_rises_reg <= oe_rises_reg + 2'h1;
   end
   sequence s_scl_low2;
      !$past(scl_in) && !scl_in;
   endsequence
   property p_oe_low;
      $changed(sda_oe) |-> s_scl_low2;
   endproperty
   property p_oe_hold;
      $rose(scl_in) |-> $stable(sda_oe)[*2];
   endproperty
   property p_zero;
      sda_out == 1'b0;
   endproperty
   property p_gate;
      !id_ready |-> oe_rises_reg < 2'h2;
   endproperty
   property p_range;
      $signed(meas_out.flow_word) <= $signed(`SICR_FLOW_MAX) && $signed(meas_out.flow_word) >= $signed(`SICR_FLOW_MIN);
   endproperty
   property p_flow;
      !$past(sys_rst) |-> meas_out.flow_word == lim($past(flow_raw));
   endproperty
   property p_temp;
      !$past(sys_rst) |-> meas_out.temp_word == $past(temp_raw);
   endproperty
   property p_rst;
      disable iff (1'b0) sys_rst |=> !sda_oe && !id_ready && meas_out == '0;
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("sda_oe moved in scl high");
   a_oe_hold: assert property (p_oe_hold) else $error("sda_oe not held");
   a_zero: assert property (p_zero) else $error("sda_out not zero");
   a_gate: assert property (p_gate) else $error("data sent unarmed");
   a_range: assert property (p_range) else $error("flow out of range");
   a_flow: assert property (p_flow) else $error("flow word wrong");
   a_temp: assert property (p_temp) else $error("temp word wrong");
   a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind sicr_readout sicr_readout_monitor i_mon (
   .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .flow_raw(flow_raw), .temp_raw(temp_raw), .meas_out(meas_out), .id_ready(id_ready));

// file: verification/sicr_master_model.sv
// Purpose: bus master facing sicr_readout
// Assumes: tasks entered at falling edges
// Notes:   released sda reads high by pull-up
`timescale 1ns/1ns
module sicr_master_model (
   input  wire logic core_clk,
   input  wire logic sda_oe,
   output logic      scl_in,
   output wire logic sda_in
);
   logic sda_m = 1'b1;
   initial scl_in = 1'b1;
   assign sda_in = sda_m && sda_oe !== 1'b1;
   task automatic hp();
      repeat (4) @(negedge core_clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      scl_in = 1'b0;
      hp();
      sda_m = b;
      hp();
      scl_in = 1'b1;
      hp();
      r = sda_in;
      hp();
   endtask
   task automatic start();
      sda_m = 1'b0;
      hp();
   endtask
   // stop: low data bit then data rises under high clock
   task automatic stop();
      logic r;
      bit_io(1'b0, r);
      sda_m = 1'b1;
      hp();
   endtask
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
   task automatic cmd(input logic [6:0] a, input logic [15:0] c, output logic [2:0] k);
      start();
      put({a, 1'b0}, k[2]);
      put(c[15:8], k[1]);
      put(c[7:0], k[0]);
      stop();
   endtask
endmodule

// file: verification/test_sensor_id_crc_readout.sv
// Purpose: self-checking bench of sicr_readout
// Assumes: master model paces the bus
// Notes:   id values arbitrary, not real codes
`timescale 1ns/1ns
module test_sensor_id_crc_readout;
   import sicr_pkg::*;
   localparam logic [6:0]  ADDR = 7'h40;
   // arbitrary product, revision and serial
   localparam logic [95:0] ID_BITS = 96'h5a3c11_07_8899aabb_ccddeeff;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        scl_in, sda_in, sda_out, sda_oe, id_ready;
   logic [15:0] flow_raw = '0;
   logic [15:0] temp_raw = '0;
   logic [15:0] c;
   logic [7:0]  rb;
   logic [2:0]  acks;
   sicr_meas_t  meas_out;
   int          miscompares = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [15:0] corner [6] = '{16'h6590, 16'h6591, 16'h9a70, 16'h9a6f, 16'h7fff, 16'h8000};
   always #5 core_clk = ~core_clk;
   sicr_readout #(.BUS_ADDR(ADDR), .PRODUCT_NUM(ID_BITS[95:72]), .REVISION(ID_BITS[71:64]),
      .SERIAL_NUM(ID_BITS[63:0])) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .flow_raw(flow_raw), .temp_raw(temp_raw),
      .meas_out(meas_out), .id_ready(id_ready));
   sicr_master_model i_host (.core_clk(core_clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
   function automatic logic [15:0] crc8(input logic [15:0] w);
      logic [7:0] r;
      r = 8'hff;
      for (int i = 15; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ w[i]) ? 8'h31 : 8'h00);
      end
      return {8'h00, r};
   endfunction
   function automatic logic [15:0] clamp(input logic [15:0] v);
      if ($signed(v) > $signed(16'h6590)) return 16'h6590;
      if ($signed(v) < $signed(16'h9a70)) return 16'h9a70;
      return v;
   endfunction
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // n bytes read, the last one answered by a refusal
   task automatic read_id(input logic arm, input int n);
      logic [15:0] w;
      i_host.start();
      i_host.put({ADDR, 1'b1}, acks[0]);
      chk("read ack", {15'h0, arm}, {15'h0, acks[0]});
      for (int k = 0; k < n; k++) begin
         i_host.get(k == n - 1, rb);
         case (k % 3)
            0: w[15:8] = rb;
            1: begin
               w[7:0] = rb;
               chk("id word", ID_BITS[95 - 16 * (k / 3) -: 16], w);
            end
            default: chk("crc", crc8(w), {8'h00, rb});
         endcase
      end
      i_host.stop();
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(32'h7dfcd22c));
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("crc ref", 16'h0092, crc8(16'hbeef));
      for (int i = 0; i < 46; i++) begin
         flow_raw = i < 6 ? corner[i] : 16'($urandom);
         temp_raw = 16'($urandom);
         @(negedge core_clk);
         chk("flow", clamp(flow_raw), meas_out.flow_word);
         if (i < 4) begin
            chk("flow ml/h", i < 2 ? 16'h0514 : 16'hfaec, 16'($signed(meas_out.flow_word) / 20));
         end
         chk("temp", temp_raw, meas_out.temp_word);
      end
      read_id(1'b0, 0);
      i_host.cmd(ADDR ^ 7'h01, 16'h367c, acks);
      chk("foreign acks", 16'h0, {13'h0, acks});
      i_host.cmd(ADDR, 16'he102, acks);
      chk("second alone", 16'h0, {15'h0, id_ready});
      i_host.cmd(ADDR, 16'h367c, acks);
      chk("acks", 16'h7, {13'h0, acks});
      i_host.cmd(ADDR, 16'he102, acks);
      chk("armed", 16'h1, {15'h0, id_ready});
      read_id(1'b1, 5);
      read_id(1'b1, 18);
      // read header for another address stays unanswered
      i_host.start();
      i_host.put({ADDR ^ 7'h01, 1'b1}, acks[0]);
      i_host.stop();
      chk("foreign read", 16'h0, {15'h0, acks[0]});
      do c = 16'($urandom); while (c == 16'h367c || c == 16'he102);
      i_host.cmd(ADDR, c, acks);
      chk("other cmd", 16'h0, {15'h0, id_ready});
      i_host.cmd(ADDR, 16'h367c, acks);
      i_host.cmd(ADDR, c, acks);
      i_host.cmd(ADDR, 16'he102, acks);
      chk("broken pair", 16'h0, {15'h0, id_ready});
      read_id(1'b0, 0);
      // mid-run reset drops the armed state
      i_host.cmd(ADDR, 16'h367c, acks);
      i_host.cmd(ADDR, 16'he102, acks);
      chk("rearmed", 16'h1, {15'h0, id_ready});
      sys_rst = 1'b1;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("reset clears", 16'h0, {15'h0, id_ready});
      read_id(1'b0, 0);
      tally_and_finish();
   end
endmodule
